// ### hw/tape_read_test_cycle_control.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Overview of operation
// - block mode checks blocks like read-after-write
// - halt-on-parity-error available in read-only mode
// - no write-inhibit line is driven
// - continuous mode suppresses longitudinal error indication
// - cycle mode rereads block in reverse
// - cycle mode forces error latch non-halting
// - direction flop toggles on each clear pulse in cycle mode, else is set forward
// - reverse direction plus drive in cycle mode drives reverse low
// - reverse start inhibits end detection, vertical check
// - check-character gap ignored while inhibit active
// - two-count counter ends inhibit, then clears
// - reverse stops twelve and half periods later
// - drive clear raises commands; next clear forward
// - end-of-data after two and half quiet periods
// - ten-period check window masks vertical parity
// - 250 ms display, its end restarts
// - halt with latched error blocks restart
module tape_read_test_cycle_control
   import tape_chk_pkg::*;
#(
   parameter int unsigned DISPLAY_CYC = (DISPLAY_MS * 1000000) / CLK_PERIOD_NS
) (
   input  wire logic        clock_in,
   input  wire logic        sys_rst_in,
   input  wire logic        clk_en_in,
   input  wire logic        read_clock_in,
   input  wire logic [8:0]  read_data_in,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             read_forward_cmd_n_out,
   output logic             read_reverse_cmd_n_out,
   output logic             vertical_parity_err_n_out,
   output logic             long_parity_err_n_out,
   output logic             end_of_block_pulse_n_out,
   output logic             display_active_out,
   output logic [8:0]       long_parity_display_out,
   output logic             vertical_parity_indicator_out,
   output logic             irq_out
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      phase_t             phase;
      logic [2:0]         rc_sync;
      logic               rc_lvl;
      logic [2:0][8:0]    data_sync;
      logic [TIMER_W-1:0] timer;
      logic               seen;
      logic               drive;
      logic               dir;
      logic               inhibit;
      logic               cnt2;
      logic               vert_err;
      logic               err_latch;
      logic [8:0]         lacc;
      logic [8:0]         long_err;
      logic [3:0]         ctrl;
      logic [IRQ_W-1:0]   irq_stat;
      logic [IRQ_W-1:0]   irq_en;
      logic               aw_got;
      logic               w_got;
      logic [7:0]         awaddr;
      logic [31:0]        wdata;
      logic               wstrb0;
      logic               awready;
      logic               wready;
      logic               bvalid;
      logic [1:0]         bresp;
      logic               arready;
      logic               rvalid;
      logic [31:0]        rdata;
      logic [1:0]         rresp;
      logic               fwd_n;
      logic               rev_n;
      logic               vpar_n;
      logic               lpar_n;
      logic               eob_n;
      logic               show;
      logic [8:0]         lpd;
      logic               irq;
   } core_t;

   localparam core_t CORE_RESET = '{
      phase: ST_IDLE, ctrl: CTRL_RESET, irq_en: IRQ_EN_RESET,
      awready: 1'b1, wready: 1'b1, arready: 1'b1,
      fwd_n: 1'b1, rev_n: 1'b1, vpar_n: 1'b1, lpar_n: 1'b1, eob_n: 1'b1,
      default: '0
   };

   localparam logic [TIMER_W-1:0] EOD_LAST     = TIMER_W'(EOD_CYC - 1);
   localparam logic [TIMER_W-1:0] CHECK_LAST   = TIMER_W'(CHECK_CYC - 1);
   localparam logic [TIMER_W-1:0] DISPLAY_LAST = TIMER_W'(DISPLAY_CYC - 1);

   core_t s_ff;
   core_t nxt_s;

   always_comb begin
      logic             rc_edge;
      logic [8:0]       ch;
      logic             run;
      logic             halt_sel;
      logic             cyc;
      logic             cont;
      logic             wr;
      logic [IRQ_W-1:0] ev;
      logic [IRQ_W-1:0] clr;
      logic [31:0]      rd;
      logic [1:0]       rresp;
      rc_edge  = 1'b0;
      ch       = s_ff.data_sync[2];
      run      = s_ff.ctrl[CTRL_RUN_BIT];
      halt_sel = s_ff.ctrl[CTRL_HALT_BIT];
      cyc      = s_ff.ctrl[CTRL_MODE_LSB +: 2] == MODE_CYCLE;
      cont     = s_ff.ctrl[CTRL_MODE_LSB +: 2] == MODE_CONT;
      wr       = 1'b0;
      ev       = '0;
      clr      = '0;
      rd       = '0;
      rresp    = RESP_OKAY;
      nxt_s    = s_ff;

      // ------------------------------------------------------------
      // read clock and data pins
      // ------------------------------------------------------------
      // a pulse counts only once the last two stages agree, filtering glitches
      nxt_s.rc_sync   = {s_ff.rc_sync[1:0], read_clock_in};
      nxt_s.data_sync = {s_ff.data_sync[1:0], read_data_in};
      if (s_ff.rc_sync[1] == s_ff.rc_sync[2]) begin
         nxt_s.rc_lvl = s_ff.rc_sync[2];
         rc_edge      = s_ff.rc_sync[2] && !s_ff.rc_lvl;
      end
      nxt_s.eob_n  = 1'b1;
      nxt_s.vpar_n = 1'b1;

      // halting is only possible with the error-stop selection outside cycle mode
      if (cyc || !halt_sel) begin
         nxt_s.err_latch = 1'b0;
      end

      // ------------------------------------------------------------
      // sequencer; the write-inhibit line is deliberately absent
      // ------------------------------------------------------------
      case (s_ff.phase)
         ST_IDLE: begin
            nxt_s.drive = 1'b0;
            if (run) begin
               // preset so the first toggle in cycle mode selects forward
               nxt_s.dir   = !cyc;
               nxt_s.phase = ST_CLEAR;
            end
         end
         ST_CLEAR: begin
            nxt_s.vert_err = 1'b0;
            nxt_s.lacc     = '0;
            nxt_s.long_err = '0;
            nxt_s.seen     = 1'b0;
            nxt_s.timer    = '0;
            nxt_s.cnt2     = 1'b0;
            nxt_s.inhibit  = 1'b0;
            nxt_s.dir      = cyc ? !s_ff.dir : 1'b1;
            if (cyc && s_ff.dir) begin
               nxt_s.inhibit = 1'b1;
            end
            nxt_s.drive = run;
            nxt_s.phase = run ? ST_RUN : ST_IDLE;
         end
         ST_RUN: begin
            if (rc_edge) begin
               nxt_s.seen  = 1'b1;
               nxt_s.timer = '0;
               nxt_s.lacc  = s_ff.lacc ^ ch;
               if (s_ff.inhibit) begin
                  // check char then first data char end the inhibit
                  nxt_s.cnt2 = 1'b1;
                  if (s_ff.cnt2) begin
                     nxt_s.inhibit = 1'b0;
                     nxt_s.cnt2    = 1'b0;
                  end
               end else if (!(^ch)) begin
                  nxt_s.vert_err = 1'b1;
                  nxt_s.vpar_n   = 1'b0;
                  ev[1]          = 1'b1;
               end
            end else if (s_ff.seen && !s_ff.inhibit) begin
               nxt_s.timer = s_ff.timer + 1'b1;
               if (s_ff.timer == EOD_LAST) begin
                  nxt_s.timer = '0;
                  nxt_s.phase = ST_CHECK;
               end
            end
            if (!run) begin
               nxt_s.phase = ST_IDLE;
            end
         end
         ST_CHECK: begin
            // check characters are accumulated but never vertically checked
            if (rc_edge) begin
               nxt_s.lacc = s_ff.lacc ^ ch;
            end
            nxt_s.timer = s_ff.timer + 1'b1;
            if (s_ff.timer == CHECK_LAST) begin
               nxt_s.timer    = '0;
               nxt_s.drive    = 1'b0;
               nxt_s.eob_n    = 1'b0;
               nxt_s.long_err = cont ? 9'h000 : s_ff.lacc;
               ev[0]          = 1'b1;
               ev[2]          = !cont && (s_ff.lacc != 9'h000);
               nxt_s.phase    = ST_SHOW;
            end
         end
         ST_SHOW: begin
            if (halt_sel && !cyc && (s_ff.vert_err || s_ff.long_err != 9'h000)) begin
               nxt_s.err_latch = 1'b1;
            end
            nxt_s.timer = s_ff.timer + 1'b1;
            if (s_ff.timer == DISPLAY_LAST) begin
               nxt_s.timer = '0;
               if (nxt_s.err_latch) begin
                  nxt_s.phase = ST_HALT;
                  ev[3]       = 1'b1;
               end else begin
                  nxt_s.phase = ST_CLEAR;
               end
            end
         end
         ST_HALT: begin
            if (!run) begin
               nxt_s.phase = ST_IDLE;
            end else if (!nxt_s.err_latch) begin
               nxt_s.phase = ST_CLEAR;
            end
         end
         default: begin
            nxt_s.phase = ST_IDLE;
         end
      endcase

      // ------------------------------------------------------------
      // register bus
      // ------------------------------------------------------------
      if (s_axi_awvalid && s_ff.awready) begin
         nxt_s.aw_got = 1'b1;
         nxt_s.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_ff.wready) begin
         nxt_s.w_got  = 1'b1;
         nxt_s.wdata  = s_axi_wdata;
         nxt_s.wstrb0 = s_axi_wstrb[0];
      end
      if (s_ff.bvalid && s_axi_bready) begin
         nxt_s.bvalid = 1'b0;
      end
      if (s_ff.aw_got && s_ff.w_got && !s_ff.bvalid) begin
         wr           = s_ff.wstrb0;
         nxt_s.aw_got = 1'b0;
         nxt_s.w_got  = 1'b0;
         nxt_s.bvalid = 1'b1;
         nxt_s.bresp  = RESP_OKAY;
         case (s_ff.awaddr)
            CTRL_OFS: begin
               if (wr) begin
                  nxt_s.ctrl = s_ff.wdata[3:0];
               end
            end
            IRQ_CLR_OFS: begin
               if (wr) begin
                  clr = s_ff.wdata[IRQ_W-1:0];
               end
            end
            IRQ_EN_OFS: begin
               if (wr) begin
                  nxt_s.irq_en = s_ff.wdata[IRQ_W-1:0];
               end
            end
            STATUS_OFS, IRQ_STAT_OFS: begin
               nxt_s.bresp = RESP_OKAY;
            end
            default: begin
               nxt_s.bresp = RESP_SLVERR;
            end
         endcase
      end
      nxt_s.awready = !nxt_s.aw_got && !nxt_s.bvalid;
      nxt_s.wready  = !nxt_s.w_got && !nxt_s.bvalid;

      case (s_axi_araddr)
         CTRL_OFS:     rd[3:0] = s_ff.ctrl;
         IRQ_STAT_OFS: rd[IRQ_W-1:0] = s_ff.irq_stat;
         IRQ_EN_OFS:   rd[IRQ_W-1:0] = s_ff.irq_en;
         IRQ_CLR_OFS:  rd = '0;
         STATUS_OFS: begin
            rd[STAT_DIR_BIT]            = s_ff.dir;
            rd[STAT_DRIVE_BIT]          = s_ff.drive;
            rd[STAT_INH_BIT]            = s_ff.inhibit;
            rd[STAT_ERRL_BIT]           = s_ff.err_latch;
            rd[STAT_VERT_BIT]           = s_ff.vert_err;
            rd[STAT_SHOW_BIT]           = s_ff.phase == ST_SHOW;
            rd[STAT_HALT_BIT]           = s_ff.phase == ST_HALT;
            rd[STAT_LONG_LSB +: 9]      = s_ff.long_err;
         end
         default: rresp = RESP_SLVERR;
      endcase
      if (s_ff.rvalid && s_axi_rready) begin
         nxt_s.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_ff.arready) begin
         nxt_s.rvalid = 1'b1;
         nxt_s.rdata  = rd;
         nxt_s.rresp  = rresp;
      end
      nxt_s.arready = !nxt_s.rvalid;

      // ------------------------------------------------------------
      // interrupts and pin outputs
      // ------------------------------------------------------------
      // an event in the clearing cycle survives the clear
      nxt_s.irq_stat = (s_ff.irq_stat & ~clr) | ev;
      nxt_s.irq      = |(nxt_s.irq_stat & nxt_s.irq_en);
      nxt_s.fwd_n    = !(nxt_s.drive && (nxt_s.dir || !cyc));
      nxt_s.rev_n    = !(nxt_s.drive && !nxt_s.dir && cyc);
      nxt_s.show     = nxt_s.phase == ST_SHOW;
      nxt_s.lpd      = nxt_s.show ? nxt_s.long_err : 9'h000;
      nxt_s.lpar_n   = !(nxt_s.show && nxt_s.long_err != 9'h000);
   end

   // stalls the whole block, including the pin synchronisers, while low
   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         s_ff <= CORE_RESET;
      end else if (clk_en_in) begin
         s_ff <= nxt_s;
      end
   end

   assign s_axi_awready                 = s_ff.awready;
   assign s_axi_wready                  = s_ff.wready;
   assign s_axi_bresp                   = s_ff.bresp;
   assign s_axi_bvalid                  = s_ff.bvalid;
   assign s_axi_arready                 = s_ff.arready;
   assign s_axi_rdata                   = s_ff.rdata;
   assign s_axi_rresp                   = s_ff.rresp;
   assign s_axi_rvalid                  = s_ff.rvalid;
   assign read_forward_cmd_n_out        = s_ff.fwd_n;
   assign read_reverse_cmd_n_out        = s_ff.rev_n;
   assign vertical_parity_err_n_out     = s_ff.vpar_n;
   assign long_parity_err_n_out         = s_ff.lpar_n;
   assign end_of_block_pulse_n_out      = s_ff.eob_n;
   assign display_active_out            = s_ff.show;
   assign long_parity_display_out       = s_ff.lpd;
   assign vertical_parity_indicator_out = s_ff.vert_err;
   assign irq_out                       = s_ff.irq;

endmodule

// ### hw/tape_chk_pkg.sv
package tape_chk_pkg;

   // ------------------------------------------------------------
   // register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS     = 8'h00;
   localparam logic [7:0] STATUS_OFS   = 8'h04;
   localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
   localparam logic [7:0] IRQ_CLR_OFS  = 8'h0C;
   localparam logic [7:0] IRQ_EN_OFS   = 8'h10;

   // ------------------------------------------------------------
   // control fields
   // ------------------------------------------------------------
   localparam int CTRL_RUN_BIT  = 0;
   localparam int CTRL_HALT_BIT = 1;
   localparam int CTRL_MODE_LSB = 2;
   localparam logic [3:0] CTRL_RESET = 4'h0;
   localparam logic [1:0] MODE_BLOCK = 2'h0;
   localparam logic [1:0] MODE_CONT  = 2'h1;
   localparam logic [1:0] MODE_CYCLE = 2'h2;

   // ------------------------------------------------------------
   // status fields
   // ------------------------------------------------------------
   localparam int STAT_DIR_BIT   = 0;
   localparam int STAT_DRIVE_BIT = 1;
   localparam int STAT_INH_BIT   = 2;
   localparam int STAT_ERRL_BIT  = 3;
   localparam int STAT_VERT_BIT  = 4;
   localparam int STAT_SHOW_BIT  = 5;
   localparam int STAT_HALT_BIT  = 6;
   localparam int STAT_LONG_LSB  = 16;

   // interrupt events: end of block, vertical error, longitudinal error, halted
   localparam int IRQ_W = 4;
   localparam logic [IRQ_W-1:0] IRQ_EN_RESET = 4'h0;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 10;
   localparam int READ_PERIOD_NS  = 1000;
   // gap measured in tenths of a read-clock period
   localparam int EOD_TENTHS      = 25;
   localparam int CHECK_PERIODS   = 10;
   localparam int EOD_CYC         = (EOD_TENTHS * READ_PERIOD_NS) / (10 * CLK_PERIOD_NS);
   localparam int CHECK_CYC       = (CHECK_PERIODS * READ_PERIOD_NS) / CLK_PERIOD_NS;
   localparam int DISPLAY_MS      = 250;
   localparam int TIMER_W         = 25;

   typedef enum logic [2:0] {ST_IDLE, ST_CLEAR, ST_RUN, ST_CHECK, ST_SHOW, ST_HALT} phase_t;

endpackage

// ### dv/tape_unit_model.sv
`timescale 1ns/100ps
module tape_unit_model (
   input  wire logic       clock_in,
   input  wire logic       fwd_cmd_n_in,
   input  wire logic       rev_cmd_n_in,
   input  wire logic [2:0] bad_sel_in,
   output logic            read_clock_out,
   output logic [8:0]      read_data_out
);
   logic rev;
   int   idx;
   initial begin
      read_clock_out = 1'b0;
      read_data_out  = 9'h1FF;
   end
   // data held well around each pulse
   task automatic send(input logic [8:0] ch, input int period);
      read_data_out <= ch;
      repeat (2) @(posedge clock_in);
      read_clock_out <= 1'b1;
      repeat (5) @(posedge clock_in);
      read_clock_out <= 1'b0;
      repeat (3) @(posedge clock_in);
      // released data shows the inverse
      read_data_out <= ~ch;
      repeat (period - 10) @(posedge clock_in);
   endtask
   always begin
      @(posedge clock_in iff (!fwd_cmd_n_in || !rev_cmd_n_in));
      rev = !rev_cmd_n_in;
      repeat (20) @(posedge clock_in);
      // backwards the check character comes first, then a four-period gap
      if (rev) send(9'h000, 400);
      for (int i = 0; i < 4; i++) begin
         idx = rev ? 3 - i : i;
         send((bad_sel_in == 3'(idx + 1)) ? 9'h003 << idx : 9'h001 << idx, 100);
      end
      @(posedge clock_in iff (fwd_cmd_n_in && rev_cmd_n_in));
   end
endmodule

// ### dv/tape_read_test_cycle_control_checker.sv
`timescale 1ns/100ps
module tape_read_test_cycle_control_checker #(
   parameter int unsigned DISPLAY_CYC = 50
) (
   input wire logic       clock_in,
   input wire logic       sys_rst_in,
   input wire logic       read_clock_in,
   input wire logic       read_forward_cmd_n_out,
   input wire logic       read_reverse_cmd_n_out,
   input wire logic       vertical_parity_err_n_out,
   input wire logic       long_parity_err_n_out,
   input wire logic       end_of_block_pulse_n_out,
   input wire logic       display_active_out,
   input wire logic [8:0] long_parity_display_out,
   input wire logic       vertical_parity_indicator_out
);
   logic [11:0] quiet_ff;
   logic [11:0] nxt_quiet;
   logic [31:0] disp_ff;
   logic [31:0] nxt_disp;
   // saturating quiet time of the read clock pin
   always_comb begin
      nxt_quiet = read_clock_in ? 12'h000 : (quiet_ff == 12'hFFF ? quiet_ff : quiet_ff + 12'h001);
      nxt_disp  = display_active_out ? disp_ff + 32'h1 : 32'h0;
   end
   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         quiet_ff <= 12'h000;
         disp_ff  <= 32'h0;
      end else begin
         quiet_ff <= nxt_quiet;
         disp_ff  <= nxt_disp;
      end
   end
   default clocking @(posedge clock_in); endclocking
   default disable iff (sys_rst_in);
   property p_eob_width;   $fell(end_of_block_pulse_n_out) |=> end_of_block_pulse_n_out; endproperty
   property p_eob_quiet;   $fell(end_of_block_pulse_n_out) |-> quiet_ff >= 12'h4C4; endproperty
   property p_eob_display; $fell(end_of_block_pulse_n_out) |-> ##[0:2] display_active_out; endproperty
   property p_eob_stop;
      $fell(end_of_block_pulse_n_out) |-> ##[0:2] (read_forward_cmd_n_out && read_reverse_cmd_n_out);
   endproperty
   property p_one_dir;     read_forward_cmd_n_out || read_reverse_cmd_n_out; endproperty
   property p_disp_len;
      $fell(display_active_out) |-> disp_ff >= DISPLAY_CYC - 1 && disp_ff <= DISPLAY_CYC + 1;
   endproperty
   property p_long_gate;
      (!long_parity_err_n_out || long_parity_display_out != 9'h000) |-> display_active_out;
   endproperty
   property p_vert_width;  !vertical_parity_err_n_out |=> vertical_parity_err_n_out; endproperty
   property p_vert_clock;  $fell(vertical_parity_err_n_out) |-> quiet_ff < 12'h010; endproperty
   property p_vert_sticky;
      $fell(vertical_parity_err_n_out) |-> ##[0:2] vertical_parity_indicator_out;
   endproperty
   a_eob_width:   assert property (p_eob_width) else $error("eob too wide");
   a_eob_quiet:   assert property (p_eob_quiet) else $error("eob too soon");
   a_eob_display: assert property (p_eob_display) else $error("no display after eob");
   a_eob_stop:    assert property (p_eob_stop) else $error("motion not stopped");
   a_one_dir:     assert property (p_one_dir) else $error("both directions");
   a_disp_len:    assert property (p_disp_len) else $error("display length");
   a_long_gate:   assert property (p_long_gate) else $error("long error outside display");
   a_vert_width:  assert property (p_vert_width) else $error("vert pulse too wide");
   a_vert_clock:  assert property (p_vert_clock) else $error("vert error off clock");
   a_vert_sticky: assert property (p_vert_sticky) else $error("vertical indicator not set");
   c_eob:  cover property ($fell(end_of_block_pulse_n_out));
   c_rev:  cover property ($fell(read_reverse_cmd_n_out));
   c_vert: cover property ($fell(vertical_parity_err_n_out));
endmodule
bind tape_read_test_cycle_control tape_read_test_cycle_control_checker #(.DISPLAY_CYC(DISPLAY_CYC))
   u_tape_read_test_cycle_control_checker (.*);

// ### dv/tape_read_test_cycle_control_test.sv
`timescale 1ns/100ps
module tape_read_test_cycle_control_test;
   import tape_chk_pkg::*;
   logic        clock_in = 1'b0, sys_rst_in = 1'b1;
   logic        rclk, awready, wready, bvalid, arready, rvalid;
   logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic [1:0]  bresp, rresp;
   logic [8:0]  rdat, ldisp;
   logic        fwd_n, rev_n, vert_n, long_n, eob_n, disp, vind, irq;
   logic [2:0]  bad_sel = 3'h0;
   logic        rc_q = 1'b0;
   int          errors = 0, total_checks = 0, cyc = 0, last_rc = 0, vcount = 0;
   tape_read_test_cycle_control #(.DISPLAY_CYC(50)) u_tape_read_test_cycle_control (
      .clock_in(clock_in), .sys_rst_in(sys_rst_in), .clk_en_in(1'b1), .read_clock_in(rclk),
      .read_data_in(rdat), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .read_forward_cmd_n_out(fwd_n),
      .read_reverse_cmd_n_out(rev_n), .vertical_parity_err_n_out(vert_n), .long_parity_err_n_out(long_n),
      .end_of_block_pulse_n_out(eob_n), .display_active_out(disp), .long_parity_display_out(ldisp),
      .vertical_parity_indicator_out(vind), .irq_out(irq));
   tape_unit_model u_tape_unit_model (.clock_in(clock_in), .fwd_cmd_n_in(fwd_n), .rev_cmd_n_in(rev_n),
      .bad_sel_in(bad_sel), .read_clock_out(rclk), .read_data_out(rdat));
   always #5 clock_in = ~clock_in;
   always @(posedge clock_in) begin
      cyc  <= cyc + 1;
      rc_q <= rclk;
      if (rclk && !rc_q) last_rc <= cyc;
      if (vert_n === 1'b0) vcount <= vcount + 1;
   end
   // ------------
   // shared tasks
   // ------------
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task give_verdict;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // bready and rready stay high
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge clock_in);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      chk("bresp", 32'(er), 32'(bresp));
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge clock_in);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      d = rdata;
      chk("rresp", 32'(er), 32'(rresp));
   endtask
   task automatic run(input logic [1:0] mode, input logic halt);
      axi_wr(CTRL_OFS, {28'h0, mode, halt, 1'b1}, RESP_OKAY);
   endtask
   task automatic wait_eob;
      while (eob_n !== 1'b0) @(posedge clock_in);
      chk("eob delay", 32'h1, 32'((cyc - last_rc) >= 1250 && (cyc - last_rc) <= 1265));
   endtask
   task automatic wait_motion(input logic rev);
      while ((rev ? rev_n : fwd_n) !== 1'b0) @(posedge clock_in);
   endtask
   task automatic stop;
      axi_wr(CTRL_OFS, 32'h0, RESP_OKAY);
      repeat (1500) @(posedge clock_in);
      axi_wr(IRQ_CLR_OFS, 32'hF, RESP_OKAY);
   endtask
   // ------------
   // scenarios
   // ------------
   task automatic t_reset;
      logic [31:0] d;
      chk("cmd idle", 32'h3, {30'h0, fwd_n, rev_n});
      axi_rd(CTRL_OFS, d, RESP_OKAY);
      chk("ctrl reset", {28'h0, CTRL_RESET}, d);
      axi_rd(IRQ_EN_OFS, d, RESP_OKAY);
      chk("irq_en reset", {28'h0, IRQ_EN_RESET}, d);
      axi_rd(8'h14, d, RESP_SLVERR);
      chk("unmapped data", 32'h0, d);
      axi_wr(8'h14, 32'h1, RESP_SLVERR);
      axi_wr(STATUS_OFS, 32'hFFFF_FFFF, RESP_OKAY);
      axi_rd(STATUS_OFS, d, RESP_OKAY);
      chk("status reset", 32'h0, 32'(d[6:1]));
   endtask
   task automatic t_block;
      logic [31:0] d;
      int          v0;
      v0 = vcount;
      axi_wr(IRQ_EN_OFS, 32'h1, RESP_OKAY);
      run(MODE_BLOCK, 1'b0);
      repeat (4) @(posedge clock_in);
      chk("forward start", 32'h1, {31'h0, rev_n & ~fwd_n});
      wait_eob;
      repeat (3) @(posedge clock_in);
      chk("long shown", 32'h1, {31'h0, disp & ~long_n & (ldisp != 9'h000)});
      chk("vert clean", 32'(v0), 32'(vcount));
      chk("irq eob", 32'h1, 32'(irq));
      axi_rd(IRQ_STAT_OFS, d, RESP_OKAY);
      chk("irq stat eob", 32'h1, 32'(d[0]));
      axi_wr(IRQ_CLR_OFS, 32'h1, RESP_OKAY);
      @(posedge clock_in);
      chk("irq cleared", 32'h0, 32'(irq));
      wait_motion(1'b0);
      chk("restart", 32'h0, 32'(fwd_n));
      stop;
   endtask
   task automatic t_halt;
      logic [31:0] d;
      int          v0;
      v0 = vcount;
      axi_wr(IRQ_EN_OFS, 32'h0, RESP_OKAY);
      bad_sel <= 3'h2;
      run(MODE_BLOCK, 1'b1);
      wait_eob;
      chk("vert count", 32'(v0 + 1), 32'(vcount));
      chk("vert indicator", 32'h1, 32'(vind));
      repeat (400) @(posedge clock_in);
      chk("halted", 32'h1, {31'h0, fwd_n & rev_n});
      chk("irq masked", 32'h0, 32'(irq));
      axi_rd(STATUS_OFS, d, RESP_OKAY);
      chk("status halt", 32'h1, 32'(d[STAT_HALT_BIT] & d[STAT_ERRL_BIT]));
      axi_rd(IRQ_STAT_OFS, d, RESP_OKAY);
      chk("irq stat", 32'h1, 32'(d[1] & d[3]));
      axi_wr(IRQ_EN_OFS, 32'h8, RESP_OKAY);
      @(posedge clock_in);
      chk("irq halted", 32'h1, 32'(irq));
      bad_sel <= 3'h0;
      run(MODE_BLOCK, 1'b0);
      wait_motion(1'b0);
      chk("halt left", 32'h0, 32'(fwd_n));
      stop;
   endtask
   task automatic t_cont;
      logic seen;
      int   v0;
      seen = 1'b0;
      v0 = vcount;
      bad_sel <= 3'h1;
      run(MODE_CONT, 1'b0);
      repeat (2500) begin
         @(posedge clock_in);
         if (long_n !== 1'b1 || ldisp !== 9'h000) seen = 1'b1;
      end
      chk("long suppressed", 32'h0, 32'(seen));
      // the window spans two blocks, each with one bad character
      chk("cont vert", 32'(v0 + 2), 32'(vcount));
      bad_sel <= 3'h0;
      stop;
   endtask
   task automatic t_cycle;
      logic [31:0] d;
      int          v0;
      bad_sel <= 3'h1;
      run(MODE_CYCLE, 1'b1);
      wait_eob;
      bad_sel <= 3'h0;
      wait_motion(1'b1);
      chk("reverse cmd", 32'h1, {31'h0, fwd_n & ~rev_n});
      axi_rd(STATUS_OFS, d, RESP_OKAY);
      chk("reverse status", 32'h6, 32'(d[2:0]));
      v0 = vcount;
      wait_eob;
      chk("check char masked", 32'(v0), 32'(vcount));
      wait_motion(1'b0);
      chk("forward again", 32'h1, {31'h0, rev_n & ~fwd_n});
      stop;
   endtask
   initial begin
      #400000;
      errors++;
      give_verdict;
   end
   initial begin
      repeat (8) @(posedge clock_in);
      sys_rst_in <= 1'b0;
      @(posedge clock_in);
      t_reset;
      t_block;
      t_halt;
      t_cont;
      t_cycle;
      give_verdict;
   end
endmodule
